//--- logic/opgpo_top.sv
`timescale 1ns/10ps
`default_nettype none

module opgpo_top #(
    parameter int OUT_INDEX = 0,
    parameter int STATIC_W = 24
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host register writes
    input wire opgpo_pkg::opgpo_wr_t host_wr,
    // register readback
    input wire logic [11:0] rd_addr,
    output logic [7:0] rd_data,
    // static output value bits
    input wire logic [STATIC_W-1:0] static_value,
    // signal format says cmos
    input wire logic fmt_is_cmos,
    // divided clocks of the pair
    input wire logic div_clk_p,
    input wire logic div_clk_n,
    // selected host bit lookup
    output opgpo_pkg::opgpo_sel_t look_sel_p,
    output opgpo_pkg::opgpo_sel_t look_sel_n,
    input wire logic look_bit_p,
    input wire logic look_bit_n,
    // pin drive
    output logic general_output_pin_p,
    output logic general_output_pin_n
);
    import opgpo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] gpo_en_reg; // per-pin enable
    logic [7:0] cfg_p_reg; // pin_p_output_mode_config
    logic [7:0] cfg_n_reg; // negative pin mode config
    logic [15:0] sel_p_reg; // positive pin selector
    logic [15:0] sel_n_reg; // pin_n_status_bit_selector

    // split a selector word into its fields
    function automatic opgpo_sel_t sel_fields(input logic [15:0] s);
        opgpo_sel_t f;
        f.bit_pos = s[OPGPO_SEL_BIT_MSB:OPGPO_SEL_BIT_LSB];
        f.page = s[OPGPO_SEL_PAGE_MSB:OPGPO_SEL_PAGE_LSB];
        f.offset = s[OPGPO_SEL_OFS_MSB:OPGPO_SEL_OFS_LSB];
        return f;
    endfunction

    // one pin's drive value from its settings
    function automatic logic pin_drive(input logic en, input logic [2:0] mode,
                                       input logic stat, input logic mirror,
                                       input logic divc, input logic held);
        logic v;
        v = held;
        if (!en) begin
            v = divc;
        end else if (fmt_is_cmos) begin
            case (mode)
                OPGPO_MODE_STATIC: v = stat;
                OPGPO_MODE_STATUS: v = mirror;
                // reserved codes keep the last level rather than glitching
                default: v = held;
            endcase
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // host writes; byte-wide, reserved bits forced to zero
    // one process per register so a write only ever touches its own byte

    // write strobe aimed at one byte address
    function automatic logic wr_hit(input opgpo_wr_t w, input logic [11:0] a);
        return w.wr && (w.addr == a);
    endfunction

    // enable byte; only the two pin bits exist
    // per-pin enable bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpo_en_reg <= OPGPO_RST_GPO_EN;
        end else if (wr_hit(host_wr, OPGPO_ADDR_GPO_EN)) begin
            // upper six bits never stick
            gpo_en_reg <= host_wr.data & OPGPO_MASK_GPO_EN;
        end
    end

    // positive pin mode byte
    // mode field, reserved bits dropped
    // a reserved code is stored as written; the drive logic then holds the pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_p_reg <= OPGPO_RST_CFG;
        end else if (wr_hit(host_wr, OPGPO_ADDR_CFG_P)) begin
            cfg_p_reg <= host_wr.data & OPGPO_MASK_CFG;
        end
    end

    // negative pin mode byte
    // mode field, reserved bits dropped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_n_reg <= OPGPO_RST_CFG;
        end else if (wr_hit(host_wr, OPGPO_ADDR_CFG_N)) begin
            cfg_n_reg <= host_wr.data & OPGPO_MASK_CFG;
        end
    end

    // positive pin selector, written as two bytes
    // selector and mode are separate writes; a new selector reaches look_sel_p one cycle after its write
    // limitation: the halves land on separate writes, so a half-updated
    // selector is briefly visible; software sets it before entering status mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_p_reg <= OPGPO_RST_SEL;
        end else begin
            // low byte holds the offset; bit 7 reserved
            if (wr_hit(host_wr, OPGPO_ADDR_SEL_P_LO)) begin
                sel_p_reg[7:0] <= host_wr.data & OPGPO_MASK_SEL[7:0];
            end
            // high byte holds bit position and page; bit 15 reserved
            if (wr_hit(host_wr, OPGPO_ADDR_SEL_P_HI)) begin
                sel_p_reg[15:8] <= host_wr.data & OPGPO_MASK_SEL[15:8];
            end
        end
    end

    // negative pin selector, same layout as the positive one
    // selector and mode are separate writes, in either order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_n_reg <= OPGPO_RST_SEL;
        end else begin
            // low byte holds the offset; bit 7 reserved
            if (wr_hit(host_wr, OPGPO_ADDR_SEL_N_LO)) begin
                sel_n_reg[7:0] <= host_wr.data & OPGPO_MASK_SEL[7:0];
            end
            // high byte holds bit position and page; bit 15 reserved
            if (wr_hit(host_wr, OPGPO_ADDR_SEL_N_HI)) begin
                sel_n_reg[15:8] <= host_wr.data & OPGPO_MASK_SEL[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback, registered; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            case (rd_addr)
                OPGPO_ADDR_GPO_EN: rd_data <= gpo_en_reg;
                OPGPO_ADDR_CFG_P: rd_data <= cfg_p_reg;
                OPGPO_ADDR_CFG_N: rd_data <= cfg_n_reg;
                OPGPO_ADDR_SEL_P_LO: rd_data <= sel_p_reg[7:0];
                OPGPO_ADDR_SEL_P_HI: rd_data <= sel_p_reg[15:8];
                OPGPO_ADDR_SEL_N_LO: rd_data <= sel_n_reg[7:0];
                OPGPO_ADDR_SEL_N_HI: rd_data <= sel_n_reg[15:8];
                default: rd_data <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selector presented to the host-map lookup, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            look_sel_p <= '0;
            look_sel_n <= '0;
        end else begin
            look_sel_p <= sel_fields(sel_p_reg);
            look_sel_n <= sel_fields(sel_n_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // static bits of this pair
    localparam int IDX_P = 2 * OUT_INDEX;
    // negative pin uses the odd index
    localparam int IDX_N = 2 * OUT_INDEX + 1;

    // positive pin drive; one flop so the pin is registered
    // mirror re-evaluated every cycle, no latching
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_output_pin_p <= 1'b0;
        end else begin
            general_output_pin_p <= pin_drive(gpo_en_reg[OPGPO_EN_P_BIT],
                cfg_p_reg[OPGPO_MODE_MSB:0], static_value[IDX_P], look_bit_p,
                div_clk_p, general_output_pin_p);
        end
    end

    // negative pin drive; same rules, odd static bit
    // the flop costs one cycle of latency, traded for a glitch-free pin
    // mirror re-evaluated every cycle, no latching
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            general_output_pin_n <= 1'b0;
        end else begin
            general_output_pin_n <= pin_drive(gpo_en_reg[OPGPO_EN_N_BIT],
                cfg_n_reg[OPGPO_MODE_MSB:0], static_value[IDX_N], look_bit_n,
                div_clk_n, general_output_pin_n);
        end
    end

endmodule

`default_nettype wire

//--- logic/opgpo_pkg.sv
// shared constants and carriers for the output-pin general-purpose output block
package opgpo_pkg;

    // register byte addresses within the host register map
    localparam logic [11:0] OPGPO_ADDR_GPO_EN = 12'h724;
    localparam logic [11:0] OPGPO_ADDR_SEL_P_LO = 12'h725;
    localparam logic [11:0] OPGPO_ADDR_SEL_P_HI = 12'h726;
    localparam logic [11:0] OPGPO_ADDR_CFG_P = 12'h727;
    localparam logic [11:0] OPGPO_ADDR_SEL_N_LO = 12'h728;
    localparam logic [11:0] OPGPO_ADDR_SEL_N_HI = 12'h729;
    localparam logic [11:0] OPGPO_ADDR_CFG_N = 12'h72A;

    // reset values
    localparam logic [7:0] OPGPO_RST_GPO_EN = 8'h00;
    localparam logic [7:0] OPGPO_RST_CFG = 8'h01;
    localparam logic [15:0] OPGPO_RST_SEL = 16'h0000;

    // field positions
    localparam int OPGPO_EN_P_BIT = 0;
    localparam int OPGPO_EN_N_BIT = 1;
    localparam int OPGPO_MODE_MSB = 2;
    localparam int OPGPO_SEL_BIT_MSB = 14;
    localparam int OPGPO_SEL_BIT_LSB = 12;
    localparam int OPGPO_SEL_PAGE_MSB = 11;
    localparam int OPGPO_SEL_PAGE_LSB = 8;
    localparam int OPGPO_SEL_OFS_MSB = 6;
    localparam int OPGPO_SEL_OFS_LSB = 0;

    // writable masks: reserved bits stay zero
    localparam logic [7:0] OPGPO_MASK_GPO_EN = 8'h03;
    localparam logic [7:0] OPGPO_MASK_CFG = 8'h07;
    localparam logic [15:0] OPGPO_MASK_SEL = 16'h7F7F;

    // mode codes of the 3-bit mode field
    localparam logic [2:0] OPGPO_MODE_STATIC = 3'h1;
    localparam logic [2:0] OPGPO_MODE_STATUS = 3'h3;

    // host register write strobe with its data
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [7:0] data;
    } opgpo_wr_t;

    // decoded status-bit selector
    typedef struct packed {
        logic [2:0] bit_pos;
        logic [3:0] page;
        logic [6:0] offset;
    } opgpo_sel_t;

endpackage

//--- tb/opgpo_checker.sv
`timescale 1ns/10ps
`default_nettype none
// pin routing checks against a shadow of the enable and mode registers
module opgpo_checker import opgpo_pkg::*; #(
    parameter int OUT_INDEX = 0,
    parameter int STATIC_W = 24
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host side
    input wire opgpo_pkg::opgpo_wr_t host_wr,
    input wire logic [11:0] rd_addr,
    input wire logic [7:0] rd_data,
    // pin sources
    input wire logic [STATIC_W-1:0] static_value,
    input wire logic fmt_is_cmos,
    input wire logic div_clk_p,
    input wire logic div_clk_n,
    input wire logic look_bit_p,
    input wire logic look_bit_n,
    // pins
    input wire logic general_output_pin_p,
    input wire logic general_output_pin_n
);
    logic [1:0] en_sh; // shadow enable bits
    logic [2:0] mp_sh, mn_sh; // shadow mode fields
    // shadow takes the same byte writes as the block
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_sh <= 2'h0;
            mp_sh <= 3'h1;
            mn_sh <= 3'h1;
        end else if (host_wr.wr) begin
            if (host_wr.addr == OPGPO_ADDR_GPO_EN) en_sh <= host_wr.data[1:0];
            if (host_wr.addr == OPGPO_ADDR_CFG_P) mp_sh <= host_wr.data[2:0];
            if (host_wr.addr == OPGPO_ADDR_CFG_N) mn_sh <= host_wr.data[2:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    clk_route_p_a: assert property (!$past(rst) && !$past(en_sh[0])
        |-> general_output_pin_p == $past(div_clk_p)) else $error("p pin off clock");
    clk_route_n_a: assert property (!$past(rst) && !$past(en_sh[1])
        |-> general_output_pin_n == $past(div_clk_n)) else $error("n pin off clock");
    static_p_a: assert property (
        !$past(rst) && $past(en_sh[0] && fmt_is_cmos && mp_sh == OPGPO_MODE_STATIC)
        |-> general_output_pin_p == $past(static_value[2*OUT_INDEX])) else $error("p static");
    static_n_a: assert property (
        !$past(rst) && $past(en_sh[1] && fmt_is_cmos && mn_sh == OPGPO_MODE_STATIC)
        |-> general_output_pin_n == $past(static_value[2*OUT_INDEX+1])) else $error("n static");
    mirror_p_a: assert property (
        !$past(rst) && $past(en_sh[0] && fmt_is_cmos && mp_sh == OPGPO_MODE_STATUS)
        |-> general_output_pin_p == $past(look_bit_p)) else $error("p mirror");
    mirror_n_a: assert property (
        !$past(rst) && $past(en_sh[1] && fmt_is_cmos && mn_sh == OPGPO_MODE_STATUS)
        |-> general_output_pin_n == $past(look_bit_n)) else $error("n mirror");
    // enabled but not usable: pin keeps its level
    hold_p_a: assert property (
        !$past(rst) && $past(en_sh[0]) && $past(!fmt_is_cmos
        || (mp_sh != OPGPO_MODE_STATIC && mp_sh != OPGPO_MODE_STATUS))
        |-> $stable(general_output_pin_p)) else $error("p pin not held");
    hold_n_a: assert property (
        !$past(rst) && $past(en_sh[1]) && $past(!fmt_is_cmos
        || (mn_sh != OPGPO_MODE_STATIC && mn_sh != OPGPO_MODE_STATUS))
        |-> $stable(general_output_pin_n)) else $error("n pin not held");
    read_cfg_a: assert property (!$past(rst) && !$past(host_wr.wr)
        && $past(rd_addr) == OPGPO_ADDR_CFG_P |-> rd_data == {5'h00, $past(mp_sh)})
        else $error("mode readback");
    cover property ($past(en_sh[0] && fmt_is_cmos && mp_sh == 3'h3));
    cover property ($past(en_sh[1] && fmt_is_cmos && mn_sh == 3'h1));
    cover property (!$past(en_sh[0]) && $rose(general_output_pin_p));
    cover property ($past(en_sh[1]) && $past(!fmt_is_cmos));
endmodule
bind opgpo_top opgpo_checker #(.OUT_INDEX(OUT_INDEX), .STATIC_W(STATIC_W)) opgpo_checker_inst (
    .ref_clk(ref_clk), .rst(rst), .host_wr(host_wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .static_value(static_value), .fmt_is_cmos(fmt_is_cmos), .div_clk_p(div_clk_p),
    .div_clk_n(div_clk_n), .look_bit_p(look_bit_p), .look_bit_n(look_bit_n),
    .general_output_pin_p(general_output_pin_p), .general_output_pin_n(general_output_pin_n));
`default_nettype wire

//--- tb/output_pin_gpo_mode_and_status_mirror_test.sv
`timescale 1ns/10ps
`default_nettype none
module output_pin_gpo_mode_and_status_mirror_test;
    import opgpo_pkg::*;
    logic ref_clk, rst, fmt_is_cmos, div_clk_p, div_clk_n, look_bit_p, look_bit_n, pp, pn;
    opgpo_wr_t host_wr; // byte writes
    opgpo_sel_t look_sel_p, look_sel_n;
    logic [11:0] rd_addr;
    logic [7:0] rd_data, erd;
    logic [23:0] static_value;
    logic [7:0] rm [12'h724:12'h72B]; // model registers, 72B stands for unmapped
    logic ep, en, chk_rd; // expected pins, readback valid
    logic ww; // write strobe being built
    logic [11:0] wa; // write address being built
    logic [7:0] wd; // write data being built
    logic [31:0] seed = 32'hD44AC853;
    int n_errors = 0, tests_run = 0, cycles = 0, quiet = 0;
    opgpo_top #(.OUT_INDEX(2), .STATIC_W(24)) opgpo_top_inst (.ref_clk(ref_clk), .rst(rst),
        .host_wr(host_wr), .rd_addr(rd_addr), .rd_data(rd_data), .static_value(static_value),
        .fmt_is_cmos(fmt_is_cmos), .div_clk_p(div_clk_p), .div_clk_n(div_clk_n),
        .look_sel_p(look_sel_p), .look_sel_n(look_sel_n), .look_bit_p(look_bit_p),
        .look_bit_n(look_bit_n), .general_output_pin_p(pp), .general_output_pin_n(pn));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // writable bits per address; reserved bits read back zero
    function automatic logic [7:0] msk(input logic [11:0] a);
        case (a)
            12'h724: return 8'h03;
            12'h727, 12'h72A: return 8'h07;
            12'h72B: return 8'h00;
            default: return 8'h7F;
        endcase
    endfunction
    // pin model: clock when disabled, else mode; anything undefined holds
    function automatic logic pin(input logic e, d, input logic [2:0] m, input logic s, b, h);
        if (!e) return d;
        if (fmt_is_cmos && m == 3'h1) return s;
        if (fmt_is_cmos && m == 3'h3) return b;
        return h;
    endfunction
    task automatic check(input string nm, input logic [13:0] exp, input logic [13:0] got);
        tests_run++;
        if (exp !== got) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // cut a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3500) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {rst, fmt_is_cmos, div_clk_p, div_clk_n, look_bit_p, look_bit_n} = 6'h20;
        {host_wr, rd_addr, static_value, ep, en} = '0;
        for (int a = 12'h724; a <= 12'h72B; a++) begin
            rm[a] = (a == 12'h727 || a == 12'h72A) ? 8'h01 : 8'h00;
        end
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            // expectation from what the block samples at this edge
            chk_rd = !host_wr.wr;
            erd = rm[rd_addr];
            ep = pin(rm[12'h724][0], div_clk_p, rm[12'h727][2:0], static_value[4], look_bit_p, ep);
            en = pin(rm[12'h724][1], div_clk_n, rm[12'h72A][2:0], static_value[5], look_bit_n, en);
            quiet = host_wr.wr ? 0 : quiet + 1;
            if (host_wr.wr) rm[host_wr.addr] = host_wr.data & msk(host_wr.addr);
            seed = xs(seed);
            // first cycles without writes so reset values get read
            ww = i > 20 && seed[3:2] == 2'h0;
            wa = 12'h724 + {9'h000, seed[6:4]};
            wd = seed[15:8];
            // selector bytes go out before any mode write
            if (i > 16 && i < 21) begin
                ww = 1'b1;
                wa = (i < 19) ? 12'h725 + 12'(i - 17) : 12'h728 + 12'(i - 19);
            end
            // mode bytes carry only the two defined codes
            if (wa == OPGPO_ADDR_CFG_P || wa == OPGPO_ADDR_CFG_N) begin
                wd[2:0] = {1'b0, seed[9], 1'b1};
            end
            host_wr <= '{wr: ww, addr: wa, data: wd};
            rd_addr <= 12'h724 + {9'h000, seed[18:16]};
            fmt_is_cmos <= seed[31:28] != 4'h0;
            {div_clk_p, div_clk_n, look_bit_p, look_bit_n} <= seed[27:24];
            static_value <= {seed[7:0], seed[31:16]};
            @(negedge ref_clk);
            check("pin_p", ep, pp);
            check("pin_n", en, pn);
            if (chk_rd) check("rd_data", erd, rd_data);
            if (quiet > 2) begin
                check("sel_p", {rm[12'h726][6:0], rm[12'h725][6:0]}, look_sel_p);
                check("sel_n", {rm[12'h729][6:0], rm[12'h728][6:0]}, look_sel_n);
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
